// [rtl/dbsc_edge.sv]
`timescale 1ns/100ps
`default_nettype none
module dbsc_edge import dbsc_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [EDGE_W-1:0] sig_in,
	output logic [EDGE_W-1:0] rise,
	output logic [EDGE_W-1:0] fall
);
	dbsc_edge_s st;
	dbsc_edge_s next_st;

	// First cycle after reset only captures, so levels present at release are no edges
	always_comb begin
		next_st = st;
		next_st.primed = 1'b1;
		next_st.prev = sig_in;
		rise = st.primed ? (sig_in & ~st.prev) : '0;
		fall = st.primed ? (~sig_in & st.prev) : '0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= EDGE_RESET;
		end else begin
			st <= next_st;
		end
	end
endmodule
`default_nettype wire

// [rtl/dbsc_pkg.sv]
package dbsc_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = DATA_W / 8;
	localparam int IDX_LSB = 2;
	localparam int IDX_W = ADDR_W - IDX_LSB;

	// Register indexes; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_CFG = 6'h02;
	localparam logic [IDX_W-1:0] IDX_IRQB_CLR = 6'h04;
	localparam logic [IDX_W-1:0] IDX_TC_CLR = 6'h06;
	localparam logic [IDX_W-1:0] IDX_STATUS = 6'h0a;
	localparam logic [IDX_W-1:0] IDX_CTRL = 6'h10;
	localparam logic [IDX_W-1:0] IDX_EVENT = 6'h12;
	localparam logic [IDX_W-1:0] IDX_MASK = 6'h14;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int PAIRS = 5;
	localparam int CAL_DACS = 3;
	localparam int CFG_W = 16;
	localparam int CTRL_W = 6;
	localparam int STATUS_W = 16;
	localparam int FILL_LSB = 7;
	localparam int FIFO_LSB = 4;
	localparam logic [STATUS_W-FILL_LSB-1:0] STATUS_FILL = 9'h1ff;

	localparam int EDGE_W = 5;
	localparam int EDGE_CNT_A = 0;
	localparam int EDGE_CNT_B = 1;
	localparam int EDGE_EXT = 2;
	localparam int EDGE_TC = 3;
	localparam int EDGE_HALF = 4;

	localparam int EVT_W = 3;
	localparam int EVT_TC = 0;
	localparam int EVT_ONE = 1;
	localparam int EVT_TWO = 2;

	localparam logic [1:0] LOAD_NONE = 2'h0;
	localparam logic [1:0] LOAD_DAC0 = 2'h1;
	localparam logic [1:0] LOAD_DAC1 = 2'h2;
	localparam logic [1:0] LOAD_DAC2 = 2'h3;
	localparam logic [CAL_DACS-1:0] STROBE_NONE = 3'h0;
	localparam logic [CAL_DACS-1:0] STROBE_DAC0 = 3'h1;
	localparam logic [CAL_DACS-1:0] STROBE_DAC1 = 3'h2;
	localparam logic [CAL_DACS-1:0] STROBE_DAC2 = 3'h4;

	typedef struct packed {
		logic [1:0] cal_dac_load_sel;
		logic fifo_replay_enable;
		logic [PAIRS-1:0] pair_format_select_n;
		logic [PAIRS-1:0] pair_double_buffer_en;
		logic eeprom_chip_enable;
		logic serial_clk;
		logic serial_shift_data;
	} dbsc_cfg_s;

	typedef struct packed {
		logic ext_update_irq_b_enable;
		logic counter_b_irq_enable;
		logic ext_update_irq_a_enable;
		logic counter_a_irq_enable;
		logic dma_transfer_enable;
		logic register_group_select;
	} dbsc_ctrl_s;

	typedef struct packed {
		logic fifo_half_full_n;
		logic fifo_empty_n;
		logic fifo_full_n;
	} dbsc_fifo_s;

	typedef struct packed {
		logic [STATUS_W-FILL_LSB-1:0] fill;
		dbsc_fifo_s fifo;
		logic irq_two_status;
		logic irq_one_status;
		logic transfer_done_irq_status;
		logic eeprom_serial_out;
	} dbsc_status_s;

	typedef struct packed {
		logic cal_sclk;
		logic eeprom_sclk;
		logic eeprom_chip_enable;
		logic serial_shift_data;
		logic [CAL_DACS-1:0] cal_load;
		logic fifo_replay_enable;
		logic [PAIRS-1:0] pair_format_select_n;
		logic [PAIRS-1:0] pair_double_buffer_en;
	} dbsc_ser_s;

	typedef struct packed {
		logic primed;
		logic [EDGE_W-1:0] prev;
	} dbsc_edge_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic arready;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [DATA_W-1:0] rdata;
		logic have_aw;
		logic have_w;
		logic [ADDR_W-1:0] awaddr;
		logic [DATA_W-1:0] wdata;
		logic [STRB_W-1:0] wstrb;
		dbsc_cfg_s cfg;
		dbsc_ctrl_s ctrl;
		logic irq_two;
		logic irq_one;
		logic tc;
		logic [EVT_W-1:0] evt;
		logic [EVT_W-1:0] mask;
		logic irq;
	} dbsc_top_s;

	localparam dbsc_top_s TOP_RESET = '0;
	localparam dbsc_ser_s SER_RESET = '0;
	localparam dbsc_edge_s EDGE_RESET = '0;

endpackage

// [rtl/dbsc_regs.sv]
// Functional notes
// - Status read returns ones in bits 15 to 7.
// - Status bit 6 shows the FIFO half-full flag, low at 512 or more.
// - Status bit 5 shows the FIFO empty flag, low when empty.
// - Status bit 4 shows the FIFO full flag, low when full.
// - Interrupt two set by counter B or update rise if enabled; clear write.
// - Interrupt one set by counter A or update rise if enabled; clear write.
// - Transfer-done set by DMA terminal count, or half-full when DMA off.
// - Status bit 0 shows the EEPROM serial output bit.
// - Load select pattern strobes calibration DAC 0, 1 or 2; 00 none.
// - Bit 13 enables FIFO replay of up to 1024 words.
// - Bits 12-8 pick per-pair data format: clear two's complement, set binary.
// - Bits 7-3 pick per-pair double buffering on the update source.
// - Bit 2 enables the calibration EEPROM.
// - Rising serial clock shifts into DACs, and EEPROM when enabled.
// - Bit 0 drives the shared serial data line.
// - Config register is write-only, written only with group select clear.
`timescale 1ns/100ps
`default_nettype none
module dbsc_regs import dbsc_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [STRB_W-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire dbsc_fifo_s fifo_flags,
	input wire logic counter_a_out,
	input wire logic counter_b_out,
	input wire logic ext_update_pulse_n,
	input wire logic dma_tc,
	input wire logic eeprom_serial_out,
	output dbsc_ser_s serial_out,
	output logic irq
);
	dbsc_top_s st;
	dbsc_top_s next_st;
	logic [EDGE_W-1:0] edge_in;
	logic [EDGE_W-1:0] rise;
	logic [EDGE_W-1:0] fall;
	logic [EVT_W-1:0] set_vec;
	logic [IDX_W-1:0] wr_idx;
	logic [IDX_W-1:0] rd_idx;
	logic wr_do;
	logic clr_one;
	logic clr_two;
	logic clr_tc;
	logic rd_evt;
	logic [CFG_W-1:0] tmp_ctrl;
	logic [CFG_W-1:0] tmp_mask;
	dbsc_status_s status;
	dbsc_cfg_s wcfg;

	// Merge the low two byte lanes of a write into a 16-bit register
	function automatic logic [CFG_W-1:0] merge16(input logic [CFG_W-1:0] old,
			input logic [DATA_W-1:0] data, input logic [STRB_W-1:0] strb);
		logic [CFG_W-1:0] res;
		res = old;
		for (int b = 0; b < CFG_W / 8; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return res;
	endfunction

	assign edge_in[EDGE_CNT_A] = counter_a_out;
	assign edge_in[EDGE_CNT_B] = counter_b_out;
	assign edge_in[EDGE_EXT] = ext_update_pulse_n;
	assign edge_in[EDGE_TC] = dma_tc;
	assign edge_in[EDGE_HALF] = fifo_flags.fifo_half_full_n;

	dbsc_edge dbsc_edge_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.sig_in(edge_in),
		.rise(rise),
		.fall(fall)
	);

	dbsc_serial dbsc_serial_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.cfg(st.cfg),
		.ser(serial_out)
	);

	always_comb begin
		status.fill = STATUS_FILL;
		status.fifo = fifo_flags;
		status.irq_two_status = st.irq_two;
		status.irq_one_status = st.irq_one;
		status.transfer_done_irq_status = st.tc;
		status.eeprom_serial_out = eeprom_serial_out;
	end

	assign wcfg = st.wdata[CFG_W-1:0];

	always_comb begin
		next_st = st;
		wr_idx = st.awaddr[ADDR_W-1:IDX_LSB];
		rd_idx = s_axi_araddr[ADDR_W-1:IDX_LSB];
		wr_do = st.have_aw && st.have_w && !st.bvalid;
		clr_one = 1'b0;
		clr_two = 1'b0;
		clr_tc = 1'b0;
		rd_evt = 1'b0;
		tmp_ctrl = merge16({{(CFG_W-CTRL_W){1'b0}}, st.ctrl}, st.wdata, st.wstrb);
		tmp_mask = merge16({{(CFG_W-EVT_W){1'b0}}, st.mask}, st.wdata, st.wstrb);

		if (s_axi_bready && st.bvalid) begin
			next_st.bvalid = 1'b0;
		end
		if (s_axi_rready && st.rvalid) begin
			next_st.rvalid = 1'b0;
		end
		if (s_axi_awvalid && st.awready) begin
			next_st.have_aw = 1'b1;
			next_st.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st.wready) begin
			next_st.have_w = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end

		// Address and data are both held; perform the write and answer
		if (wr_do) begin
			next_st.have_aw = 1'b0;
			next_st.have_w = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = RESP_OKAY;
			unique case (wr_idx)
				IDX_CFG: begin
					if (st.ctrl.register_group_select) begin
						clr_one = 1'b1;
					end else begin
						next_st.cfg = merge16(st.cfg, st.wdata, st.wstrb);
					end
				end
				IDX_IRQB_CLR: begin
					clr_two = st.ctrl.register_group_select;
				end
				IDX_TC_CLR: begin
					clr_tc = st.ctrl.register_group_select;
				end
				IDX_CTRL: begin
					next_st.ctrl = tmp_ctrl[CTRL_W-1:0];
				end
				IDX_MASK: begin
					next_st.mask = tmp_mask[EVT_W-1:0];
				end
				default: begin
					next_st.bresp = RESP_SLVERR;
				end
			endcase
		end

		if (s_axi_arvalid && st.arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = RESP_OKAY;
			next_st.rdata = '0;
			unique case (rd_idx)
				IDX_STATUS: begin
					next_st.rdata[STATUS_W-1:0] = status;
				end
				IDX_CTRL: begin
					next_st.rdata[CTRL_W-1:0] = st.ctrl;
				end
				IDX_EVENT: begin
					next_st.rdata[EVT_W-1:0] = st.evt;
					rd_evt = 1'b1;
				end
				IDX_MASK: begin
					next_st.rdata[EVT_W-1:0] = st.mask;
				end
				// Write-only locations read as zero
				IDX_CFG, IDX_IRQB_CLR, IDX_TC_CLR: begin
					next_st.rdata = '0;
				end
				default: begin
					next_st.rresp = RESP_SLVERR;
				end
			endcase
		end

		set_vec[EVT_TWO] = (rise[EDGE_CNT_B] & st.ctrl.counter_b_irq_enable) |
			(rise[EDGE_EXT] & st.ctrl.ext_update_irq_b_enable);
		set_vec[EVT_ONE] = (rise[EDGE_CNT_A] & st.ctrl.counter_a_irq_enable) |
			(rise[EDGE_EXT] & st.ctrl.ext_update_irq_a_enable);
		set_vec[EVT_TC] = st.ctrl.dma_transfer_enable ? rise[EDGE_TC] :
			fall[EDGE_HALF];

		// A set in the same cycle as its clear wins
		next_st.irq_two = (st.irq_two & ~clr_two) | set_vec[EVT_TWO];
		next_st.irq_one = (st.irq_one & ~clr_one) | set_vec[EVT_ONE];
		next_st.tc = (st.tc & ~clr_tc) | set_vec[EVT_TC];
		next_st.evt = (st.evt & ~{EVT_W{rd_evt}}) | set_vec;
		next_st.irq = |(next_st.evt & next_st.mask);

		next_st.awready = !next_st.have_aw && !next_st.bvalid;
		next_st.wready = !next_st.have_w && !next_st.bvalid;
		next_st.arready = !next_st.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= TOP_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_awready = st.awready;
	assign s_axi_wready = st.wready;
	assign s_axi_bresp = st.bresp;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_arready = st.arready;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign s_axi_rvalid = st.rvalid;
	assign irq = st.irq;

	status_upper_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && st.arready && rd_idx == IDX_STATUS)
		|=> (st.rvalid && st.rresp == RESP_OKAY &&
			st.rdata[STATUS_W-1:FILL_LSB] == STATUS_FILL))
		else $error("status upper bits not all ones");

	fifo_flags_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && st.arready && rd_idx == IDX_STATUS)
		|=> (st.rdata[FILL_LSB-1:FIFO_LSB] == $past(fifo_flags)))
		else $error("status fifo flags do not follow the fifo");

	prom_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && st.arready && rd_idx == IDX_STATUS)
		|=> (st.rdata[0] == $past(eeprom_serial_out) &&
			st.rdata[EVT_TWO+1:1] == $past({st.irq_two, st.irq_one, st.tc})))
		else $error("status eeprom or interrupt bits wrong");

	irq_two_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		($past(aresetn) && counter_b_out && !$past(counter_b_out) &&
			st.ctrl.counter_b_irq_enable)
		|=> st.irq_two)
		else $error("interrupt two not set by counter b rise");

	irq_one_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_do && wr_idx == IDX_CFG && st.ctrl.register_group_select &&
			!set_vec[EVT_ONE])
		|=> !st.irq_one)
		else $error("interrupt one not cleared by its clear write");

	half_full_tc_a: assert property (@(posedge aclk) disable iff (!aresetn)
		($past(aresetn) && !st.ctrl.dma_transfer_enable &&
			$fell(fifo_flags.fifo_half_full_n))
		|=> st.tc)
		else $error("transfer done not set by half full");

	cal_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(st.cfg.cal_dac_load_sel == LOAD_DAC1)
		|=> (serial_out.cal_load == STROBE_DAC1))
		else $error("calibration dac one load strobe missing");

	eeprom_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(st.cfg.serial_clk && !st.cfg.eeprom_chip_enable)
		|=> (!serial_out.eeprom_sclk && serial_out.cal_sclk &&
			!serial_out.eeprom_chip_enable))
		else $error("eeprom clock not gated by chip enable");

	pair_fields_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_do && wr_idx == IDX_CFG && !st.ctrl.register_group_select &&
			&st.wstrb[1:0])
		|=> ##1 (serial_out.pair_format_select_n == $past(wcfg.pair_format_select_n, 2) &&
			serial_out.pair_double_buffer_en == $past(wcfg.pair_double_buffer_en, 2) &&
			serial_out.fifo_replay_enable == $past(wcfg.fifo_replay_enable, 2) &&
			serial_out.serial_shift_data == $past(wcfg.serial_shift_data, 2)))
		else $error("config fields not driven out");

	group_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_do && wr_idx == IDX_CFG && st.ctrl.register_group_select)
		|=> $stable(st.cfg))
		else $error("config written while group select set");

	reset_clear_a: assert property (@(posedge aclk)
		!aresetn |=> (st.cfg == '0 && !st.irq_one && !st.irq_two && !st.tc &&
			!st.irq))
		else $error("reset did not clear flags and config");

	irq_one_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		($past(aresetn) && counter_a_out && !$past(counter_a_out) &&
			st.ctrl.counter_a_irq_enable)
		|=> st.irq_one)
		else $error("interrupt one not set by counter a rise");

	ext_update_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		($past(aresetn) && $rose(ext_update_pulse_n) &&
			st.ctrl.ext_update_irq_a_enable && st.ctrl.ext_update_irq_b_enable)
		|=> (st.irq_one && st.irq_two))
		else $error("update pulse end did not set both interrupts");

	dma_tc_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		($past(aresetn) && st.ctrl.dma_transfer_enable && $rose(dma_tc))
		|=> st.tc)
		else $error("transfer done not set by terminal count");

	irq_two_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_do && wr_idx == IDX_IRQB_CLR && st.ctrl.register_group_select &&
			!set_vec[EVT_TWO])
		|=> !st.irq_two)
		else $error("interrupt two not cleared by its clear write");

	tc_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_do && wr_idx == IDX_TC_CLR && st.ctrl.register_group_select &&
			!set_vec[EVT_TC])
		|=> !st.tc)
		else $error("transfer done not cleared by its clear write");

	event_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && st.arready && rd_idx == IDX_EVENT && set_vec == '0)
		|=> (st.evt == '0 && !st.irq))
		else $error("event read did not clear events and interrupt");

	cal_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(st.cfg.cal_dac_load_sel == LOAD_NONE)
		|=> (serial_out.cal_load == STROBE_NONE))
		else $error("calibration dac strobe without a load pattern");

endmodule
`default_nettype wire

// [rtl/dbsc_serial.sv]
`timescale 1ns/100ps
`default_nettype none
module dbsc_serial import dbsc_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire dbsc_cfg_s cfg,
	output dbsc_ser_s ser
);
	dbsc_ser_s st;
	dbsc_ser_s next_st;

	always_comb begin
		next_st = st;
		next_st.cal_sclk = cfg.serial_clk;
		next_st.eeprom_sclk = cfg.serial_clk & cfg.eeprom_chip_enable;
		next_st.eeprom_chip_enable = cfg.eeprom_chip_enable;
		next_st.serial_shift_data = cfg.serial_shift_data;
		next_st.fifo_replay_enable = cfg.fifo_replay_enable;
		next_st.pair_format_select_n = cfg.pair_format_select_n;
		next_st.pair_double_buffer_en = cfg.pair_double_buffer_en;
		unique case (cfg.cal_dac_load_sel)
			LOAD_NONE: next_st.cal_load = STROBE_NONE;
			LOAD_DAC0: next_st.cal_load = STROBE_DAC0;
			LOAD_DAC1: next_st.cal_load = STROBE_DAC1;
			LOAD_DAC2: next_st.cal_load = STROBE_DAC2;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= SER_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign ser = st;
endmodule
`default_nettype wire

// [verif/dac_board_status_config_regs_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module dac_board_status_config_regs_tb import dbsc_pkg::*; ;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic ca = 0, cb = 0, dma_tc = 0, ext_n = 1;
	logic [DATA_W-1:0] wdata = '0, rdata, last_data;
	logic [STRB_W-1:0] wstrb = '0;
	logic [STRB_W-1:0] strb_sel = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, irq, eeprom_out;
	logic [1:0] bresp, rresp, last_resp;
	dbsc_ser_s serial_out;
	dbsc_fifo_s fifo_flags = 3'h7;
	int error_cnt = 0, compares = 0, cycles = 0;
	// Config word beside the serial outputs it should give
	logic [33:0] rows [12] = '{{16'h0000, 18'h00000}, {16'h4000, 18'h00800},
		{16'h8000, 18'h01000}, {16'hc000, 18'h02000}, {16'h2000, 18'h00400},
		{16'h1f00, 18'h003e0}, {16'h00f8, 18'h0001f}, {16'h0007, 18'h3c000},
		{16'h0003, 18'h24000}, {16'h0006, 18'h38000}, {16'h0a50, 18'h0014a},
		{16'hffff, 18'h3e7ff}};

	dbsc_regs dbsc_regs_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .fifo_flags(fifo_flags), .counter_a_out(ca),
		.counter_b_out(cb), .ext_update_pulse_n(ext_n), .dma_tc(dma_tc),
		.eeprom_serial_out(eeprom_out), .serial_out(serial_out), .irq(irq));
	dbsc_cal_model dbsc_cal_model_inst (.aclk(aclk), .ser(serial_out),
		.eeprom_serial_out(eeprom_out));

	initial begin
		forever #25 aclk = ~aclk;
	end

	task automatic summarize();
		$display("Comparisons %0d, errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	always @(posedge aclk) begin
		cycles++;
		if (cycles == 6000) begin
			error_cnt++;
			summarize();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask

	task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] d);
		@(posedge aclk);
		awaddr <= {idx, 2'h0};
		wdata <= {16'h0, d};
		wstrb <= strb_sel;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		last_resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [IDX_W-1:0] idx);
		@(posedge aclk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		last_data = rdata;
		last_resp = rresp;
		rready <= 1'b0;
	endtask

	task automatic rchk(input logic [IDX_W-1:0] idx, input logic [15:0] exp);
		rd(idx);
		chk({16'h0, last_data[15:0]}, {16'h0, exp});
	endtask

	task automatic sbit(input logic b, input logic en);
		wr(IDX_CFG, {13'h0, en, 1'b0, b});
		wr(IDX_CFG, {13'h0, en, 1'b1, b});
	endtask

	// Bit 0 counter A, 1 counter B, 2 terminal count, 3 update pulse
	task automatic pulse(input logic [3:0] s);
		@(posedge aclk);
		ca <= s[0];
		cb <= s[1];
		dma_tc <= s[2];
		ext_n <= ~s[3];
		wt(2);
		@(posedge aclk);
		ca <= 1'b0;
		cb <= 1'b0;
		dma_tc <= 1'b0;
		ext_n <= 1'b1;
		wt(3);
	endtask

	initial begin
		logic [7:0] v;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		wt(1);
		chk(serial_out, '0);
		rchk(IDX_STATUS, 16'hfff1);
		foreach (rows[i]) begin
			wr(IDX_CFG, rows[i][33:18]);
			wt(2);
			chk(serial_out, rows[i][17:0]);
		end
		rchk(IDX_CFG, 16'h0000);
		chk(last_resp, RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			@(posedge aclk);
			fifo_flags <= {1'b1, i[1:0]};
			rchk(IDX_STATUS, {10'h3ff, i[1:0], 4'h1});
		end
		// Upper byte lane only: low byte must keep its ones
		strb_sel = 4'h2;
		wr(IDX_CFG, 16'h0000);
		strb_sel = 4'hf;
		wt(2);
		chk(serial_out, 18'h3c01f);
		wr(IDX_CFG, 16'h0000);
		wr(IDX_CFG, 16'h0002);
		wr(IDX_CFG, 16'h0000);
		sbit(1'b1, 1'b1);
		rchk(IDX_STATUS, 16'hfff1);
		sbit(1'b0, 1'b1);
		rchk(IDX_STATUS, 16'hfff0);
		for (int k = 0; k < 3; k++) begin
			v = 8'ha5 + 8'(k);
			for (int j = 7; j >= 0; j--) sbit(v[j], 1'b0);
			wr(IDX_CFG, {2'(k + 1), 14'h0});
			wr(IDX_CFG, 16'h0000);
		end
		for (int k = 0; k < 3; k++) chk(dbsc_cal_model_inst.dac_val[k], 8'ha5 + 8'(k));
		wr(IDX_CTRL, 16'h003c);
		wr(IDX_MASK, 16'h0007);
		pulse(4'h1);
		chk(irq, 1'b1);
		rchk(IDX_STATUS, 16'hfff5);
		rchk(IDX_EVENT, 16'h0002);
		rchk(IDX_EVENT, 16'h0000);
		wt(2);
		chk(irq, 1'b0);
		pulse(4'h2);
		rchk(IDX_STATUS, 16'hfffd);
		wr(IDX_CTRL, 16'h003d);
		wr(IDX_CFG, 16'hffff);
		wr(IDX_IRQB_CLR, 16'h0000);
		wt(1);
		chk(serial_out, '0);
		rchk(IDX_STATUS, 16'hfff1);
		wr(IDX_CTRL, 16'h003c);
		pulse(4'h8);
		rchk(IDX_STATUS, 16'hfffd);
		@(posedge aclk);
		fifo_flags <= 3'h3;
		wt(3);
		rchk(IDX_STATUS, 16'hffbf);
		rchk(IDX_EVENT, 16'h0007);
		wr(IDX_CTRL, 16'h003d);
		wr(IDX_CFG, 16'h0000);
		wr(IDX_IRQB_CLR, 16'h0000);
		rchk(IDX_STATUS, 16'hffb3);
		wr(IDX_TC_CLR, 16'h0000);
		rchk(IDX_STATUS, 16'hffb1);
		wr(IDX_CTRL, 16'h0002);
		wr(IDX_MASK, 16'h0000);
		@(posedge aclk);
		fifo_flags <= 3'h7;
		pulse(4'h3);
		@(posedge aclk);
		fifo_flags <= 3'h3;
		wt(3);
		rchk(IDX_STATUS, 16'hffb1);
		pulse(4'h4);
		rchk(IDX_STATUS, 16'hffb3);
		chk(irq, 1'b0);
		wr(IDX_MASK, 16'h0001);
		wt(2);
		chk(irq, 1'b1);
		wr(IDX_STATUS, 16'h0000);
		chk(last_resp, RESP_SLVERR);
		rd(6'h3f);
		chk(last_resp, RESP_SLVERR);
		wr(IDX_CFG, 16'h2a07);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		wt(2);
		chk(serial_out, '0);
		rchk(IDX_STATUS, 16'hffb0);
		chk(irq, 1'b0);
		summarize();
	end
endmodule
`default_nettype wire

// [verif/dbsc_cal_model.sv]
`timescale 1ns/100ps
`default_nettype none
module dbsc_cal_model import dbsc_pkg::*; #(
	parameter int CAL_W = 8
) (
	input wire logic aclk,
	input wire dbsc_ser_s ser,
	output logic eeprom_serial_out
);
	logic [CAL_DACS-1:0][CAL_W-1:0] shift_q = '0;
	logic [CAL_DACS-1:0][CAL_W-1:0] dac_val = '0;
	logic [CAL_DACS-1:0] load_d = '0;
	logic prom_q = 1'b0;
	logic sclk_d = 1'b0;
	logic prom_sclk_d = 1'b0;

	// Deselected part releases its output: shows the inverse of the last bit
	assign eeprom_serial_out = ser.eeprom_chip_enable ? prom_q : ~prom_q;

	always @(posedge aclk) begin
		sclk_d <= ser.cal_sclk;
		prom_sclk_d <= ser.eeprom_sclk;
		load_d <= ser.cal_load;
		for (int i = 0; i < CAL_DACS; i++) begin
			if (ser.cal_sclk && !sclk_d) begin
				shift_q[i] <= {shift_q[i][CAL_W-2:0], ser.serial_shift_data};
			end
			if (ser.cal_load[i] && !load_d[i]) begin
				dac_val[i] <= shift_q[i];
			end
		end
		if (ser.eeprom_sclk && !prom_sclk_d && ser.eeprom_chip_enable) begin
			prom_q <= ser.serial_shift_data;
		end
	end
endmodule
`default_nettype wire
